// file: isa_host_probe.sv
// Purpose: isa host side issuing io reads into the device range
// Assumes: answer is sampled the edge after the probe is taken
// Notes:   address is inverted when released so no stale value lingers
`timescale 1ns/1ps
`default_nettype none
module isa_host_probe (
	// clock
	input wire logic        clk_sys,
	// io read probe
	output var logic [15:0] io_addr,
	output var logic        io_read,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rdata_valid
);
	initial begin
		io_addr = 16'h0000;
		io_read = 1'b0;
	end
	// one io read cycle, answer and its valid flag returned
	task automatic probe(input logic [15:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_sys);
		io_addr <= a;
		io_read <= 1'b1;
		@(posedge clk_sys);
		io_read <= 1'b0;
		io_addr <= ~a;
		@(posedge clk_sys);
		d = io_rdata;
		v = io_rdata_valid;
	endtask
endmodule // isa_host_probe
`default_nettype wire

// file: ldcfg_bank.sv
// Purpose: logical device configuration registers and memory programming
// Assumes: AXI4-Lite slave, byte address = 4 * index, 8 bit data in low bits
// Notes:   range-check answers appear on the io read port
//          one write and one read may be outstanding at a time
//          a proceed write starts a timed memory cycle; status shows busy
//          the memory array has no reset; unwritten words read unknown
//          index 0x07 picks the logical device that the per-device registers address
//          only byte lane 0 carries data; upper read bits are zero
`timescale 1ns/1ps
`default_nettype none
module ldcfg_bank
	import ldcfg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// axi4-lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// isa io read probe for range check
	input  wire logic [15:0] io_addr,
	input  wire logic        io_read,
	output logic [7:0]       io_rdata,
	output logic             io_rdata_valid,
	// resulting configuration of the selected device
	output logic             device_active,
	output logic [3:0]       interrupt_line_number0,
	output logic [3:0]       interrupt_line_number1,
	output logic [2:0]       dma_channel
);
	localparam int DW = $clog2(NUM_DEVICES);

	typedef enum logic [1:0] {PROG_IDLE, PROG_RUN} prog_state_type;

	// per-device configuration storage
	logic [7:0]  act_reg      [NUM_DEVICES];
	logic [7:0]  rc_reg       [NUM_DEVICES];
	logic [15:0] base_reg     [NUM_DEVICES][3];
	logic [7:0]  lvl_reg      [NUM_DEVICES][2];
	logic [7:0]  typ_reg      [NUM_DEVICES][2];
	logic [7:0]  dma_reg      [NUM_DEVICES];
	logic [DW-1:0] sel_reg;
	// programming interface
	logic [7:0]  cmd_reg;
	logic [7:0]  paddr_reg;
	logic [15:0] pdata_reg;
	logic [15:0] mem [MEM_WORDS];
	prog_state_type prog_state_reg;
	logic [15:0] prog_cnt_reg;
	logic        done_reg;
	// bus slave state
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_idx_reg;
	logic [7:0]  w_data_reg;
	logic        w_lane_reg;
	logic        do_write;
	logic [7:0]  wr_idx;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic [8:0]  rd_word;
	logic [8:0]  wr_word;

	// convert a byte address into a register index
	// the two low bits and bits 11..10 are ignored, so indices alias
	function automatic logic [7:0] to_index(input logic [11:0] a);
		return a[9:2];
	endfunction

	// read mux shared by bus reads and write-target checks
	// bit 8 marks a mapped index; unmapped ones read zero
	function automatic logic [8:0] read_reg(input logic [7:0] idx,
		input logic [DW-1:0] d);
		case (idx)
			IDX_PROGRAM_STATUS:    return {1'b1, 7'h00, done_reg};
			IDX_DEVICE_SELECT:     return {1'b1, RESET_BYTE};
			IDX_DEVICE_ACTIVATION: return {1'b1, 7'h00, act_reg[d][ACT_BIT]};
			IDX_RANGE_CHECK:       return {1'b1, 6'h00, rc_reg[d][1:0]};
			IDX_IO_BASE0_HIGH:     return {1'b1, base_reg[d][0][15:8]};
			IDX_IO_BASE0_LOW:      return {1'b1, base_reg[d][0][7:0]};
			IDX_IO_BASE1_HIGH:     return {1'b1, base_reg[d][1][15:8]};
			IDX_IO_BASE1_LOW:      return {1'b1, base_reg[d][1][7:0]};
			IDX_IO_BASE2_HIGH:     return {1'b1, base_reg[d][2][15:8]};
			IDX_IO_BASE2_LOW:      return {1'b1, base_reg[d][2][7:0]};
			IDX_IRQ_LEVEL_SEL0:    return {1'b1, 4'h0, lvl_reg[d][0][3:0]};
			IDX_IRQ_TYPE_SEL0:     return {1'b1, typ_reg[d][0]};
			IDX_IRQ_LEVEL_SEL1:    return {1'b1, 4'h0, lvl_reg[d][1][3:0]};
			IDX_IRQ_TYPE_SEL1:     return {1'b1, typ_reg[d][1]};
			IDX_DMA_CHANNEL_SEL0:  return {1'b1, 5'h00, dma_reg[d][2:0]};
			IDX_PROGRAM_COMMAND:   return {1'b1, cmd_reg};
			IDX_PROGRAM_ADDRESS:   return {1'b1, paddr_reg};
			IDX_PROGRAM_DATA_HIGH: return {1'b1, pdata_reg[15:8]};
			IDX_PROGRAM_DATA_LOW:  return {1'b1, pdata_reg[7:0]};
			default:               return {1'b0, 8'h00};
		endcase
	endfunction

	// bus timing: aw and w are taken in either order; the response
	// follows one cycle after both are held and stands until bready;
	// a read answers one cycle after its address and stands until
	// rready, and no new address is taken meanwhile
	// write channel handshakes: accept each once, until the response goes
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_idx        = aw_idx_reg;

	// capture write address and data in either order
	// each half is held until both are in and the response is sent
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= to_index(s_axi_awaddr);
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// write response: slverr on unmapped or read-only index
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_word[8] &&
				wr_idx != IDX_PROGRAM_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// device select, written through index 0x07
	// only the low bits are kept, so larger numbers alias
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_reg <= '0;
		end else if (do_write && w_lane_reg && wr_idx == IDX_DEVICE_SELECT) begin
			sel_reg <= w_data_reg[DW-1:0];
		end
	end

	// per-device configuration writes go to the selected device
	// a write with lane 0 off is answered but changes nothing
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_DEVICES; i++) begin
				act_reg[i] <= RESET_BYTE;
				rc_reg[i]  <= RESET_BYTE;
				dma_reg[i] <= RESET_DMA_NONE;
				for (int j = 0; j < 3; j++) base_reg[i][j] <= 16'h0000;
				for (int j = 0; j < 2; j++) begin
					lvl_reg[i][j] <= RESET_BYTE;
					typ_reg[i][j] <= RESET_BYTE;
				end
			end
		end else if (do_write && w_lane_reg) begin
			case (wr_idx)
				IDX_DEVICE_ACTIVATION: act_reg[sel_reg] <= w_data_reg;
				IDX_RANGE_CHECK:       rc_reg[sel_reg]  <= w_data_reg;
				IDX_IO_BASE0_HIGH:     base_reg[sel_reg][0][15:8] <= w_data_reg;
				IDX_IO_BASE0_LOW:      base_reg[sel_reg][0][7:0]  <= w_data_reg;
				IDX_IO_BASE1_HIGH:     base_reg[sel_reg][1][15:8] <= w_data_reg;
				IDX_IO_BASE1_LOW:      base_reg[sel_reg][1][7:0]  <= w_data_reg;
				IDX_IO_BASE2_HIGH:     base_reg[sel_reg][2][15:8] <= w_data_reg;
				IDX_IO_BASE2_LOW:      base_reg[sel_reg][2][7:0]  <= w_data_reg;
				IDX_IRQ_LEVEL_SEL0:    lvl_reg[sel_reg][0] <= w_data_reg;
				IDX_IRQ_TYPE_SEL0:     typ_reg[sel_reg][0] <= w_data_reg;
				IDX_IRQ_LEVEL_SEL1:    lvl_reg[sel_reg][1] <= w_data_reg;
				IDX_IRQ_TYPE_SEL1:     typ_reg[sel_reg][1] <= w_data_reg;
				IDX_DMA_CHANNEL_SEL0:  dma_reg[sel_reg]    <= w_data_reg;
				default: ;
			endcase
		end
	end

	// programming address, data and command; the engine overwrites data
	// a finishing read wins over a bus write to the data bytes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_reg   <= RESET_BYTE;
			paddr_reg <= RESET_BYTE;
			pdata_reg <= 16'h0000;
		end else begin
			if (do_write && w_lane_reg && wr_idx == IDX_PROGRAM_COMMAND)
				cmd_reg <= w_data_reg;
			else if (prog_state_reg == PROG_RUN && prog_cnt_reg == 16'h0000)
				cmd_reg[CMD_PROCEED_BIT] <= 1'b0;
			if (do_write && w_lane_reg && wr_idx == IDX_PROGRAM_ADDRESS)
				paddr_reg <= w_data_reg;
			if (prog_state_reg == PROG_RUN && prog_cnt_reg == 16'h0000 &&
				cmd_reg[1:0] == OP_READ)
				pdata_reg <= mem[paddr_reg];
			else if (do_write && w_lane_reg && wr_idx == IDX_PROGRAM_DATA_HIGH)
				pdata_reg[15:8] <= w_data_reg;
			else if (do_write && w_lane_reg && wr_idx == IDX_PROGRAM_DATA_LOW)
				pdata_reg[7:0] <= w_data_reg;
		end
	end

	// programming engine: a proceed write starts a timed operation
	// a command written while busy is stored but starts nothing, so the
	// host must see done before the next command
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prog_state_reg <= PROG_IDLE;
			prog_cnt_reg   <= 16'h0000;
			done_reg       <= 1'b1;
		end else begin
			case (prog_state_reg)
				PROG_IDLE: begin
					if (do_write && w_lane_reg && wr_idx == IDX_PROGRAM_COMMAND &&
						w_data_reg[CMD_PROCEED_BIT] &&
						w_data_reg[1:0] != 2'b00) begin
						prog_state_reg <= PROG_RUN;
						prog_cnt_reg   <= 16'(PROG_CYCLES - 1);
						done_reg       <= 1'b0;
					end
				end
				PROG_RUN: begin
					if (prog_cnt_reg == 16'h0000) begin
						prog_state_reg <= PROG_IDLE;
						done_reg       <= 1'b1;
					end else begin
						prog_cnt_reg <= prog_cnt_reg - 16'h0001;
					end
				end
				default: prog_state_reg <= PROG_IDLE;
			endcase
		end
	end

	// configuration memory array, written or erased at the end of a cycle
	// no reset here: contents survive a bus reset
	always_ff @(posedge clk_sys) begin
		if (prog_state_reg == PROG_RUN && prog_cnt_reg == 16'h0000) begin
			if (cmd_reg[1:0] == OP_WRITE)
				mem[paddr_reg] <= pdata_reg;
			else if (cmd_reg[1:0] == OP_ERASE)
				mem[paddr_reg] <= ERASED_WORD;
		end
	end

	// read channel: one read at a time, data one cycle after address
	assign s_axi_arready = !s_axi_rvalid;
	// decode in a process, so it follows every register it reads
	always_comb begin
		rd_word = read_reg(to_index(s_axi_araddr), sel_reg);
		wr_word = read_reg(wr_idx, sel_reg);
	end
	assign rd_byte = rd_word[7:0];
	assign rd_hit  = rd_word[8];

	// read answer, held until rready
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// range check answer for io reads inside any descriptor base window
	// exact match on each base only: the window sizes are not known here
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			io_rdata       <= 8'h00;
			io_rdata_valid <= 1'b0;
		end else begin
			io_rdata_valid <= 1'b0;
			if (io_read && rc_reg[sel_reg][RC_ENABLE_BIT] &&
				!act_reg[sel_reg][ACT_BIT] &&
				(io_addr == base_reg[sel_reg][0] ||
				 io_addr == base_reg[sel_reg][1] ||
				 io_addr == base_reg[sel_reg][2])) begin
				io_rdata_valid <= 1'b1;
				io_rdata <= rc_reg[sel_reg][RC_PATTERN_BIT] ?
					RC_PATTERN_SET : RC_PATTERN_CLEAR;
			end
		end
	end

	// selected device configuration outputs
	// these follow the device select at once
	assign device_active          = act_reg[sel_reg][ACT_BIT];
	assign interrupt_line_number0 = lvl_reg[sel_reg][0][3:0];
	assign interrupt_line_number1 = lvl_reg[sel_reg][1][3:0];
	assign dma_channel            = dma_reg[sel_reg][2:0];
endmodule // ldcfg_bank
`default_nettype wire

// file: ldcfg_bank_asserts.sv
// Purpose: port checks for the logical device configuration bank
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ldcfg_bank_asserts
	import ldcfg_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	// register bus
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// io probe and configuration
	input wire logic        io_read,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rdata_valid,
	input wire logic        device_active,
	input wire logic [2:0]  dma_channel
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// read request accepted by the slave
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// range answers carry one of two patterns, only after a probe
	a_io_pattern: assert property (
		io_rdata_valid |->
		io_rdata == RC_PATTERN_SET || io_rdata == RC_PATTERN_CLEAR)
		else $error("io answer pattern wrong");
	a_io_cause: assert property (
		io_rdata_valid |-> $past(io_read))
		else $error("io answer without probe");
	a_io_inactive: assert property (
		io_rdata_valid |-> !$past(device_active))
		else $error("io answer while device active");
	// defaults right after reset
	a_reset_defaults: assert property (
		$fell(sys_rst) |-> dma_channel == 3'h4 && !device_active)
		else $error("reset defaults wrong");
	// registers are bytes in the low lane
	a_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	a_read_answer: assert property (
		rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_bvalid_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	c_io_answer: cover property (io_rdata_valid);
endmodule // ldcfg_bank_asserts
bind ldcfg_bank ldcfg_bank_asserts ldcfg_bank_asserts_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.io_read(io_read), .io_rdata(io_rdata),
	.io_rdata_valid(io_rdata_valid), .device_active(device_active),
	.dma_channel(dma_channel));
`default_nettype wire

// file: ldcfg_bank_test.sv
// Purpose: register and programming checks of the configuration bank
// Assumes: byte address is four times the register index
// Notes:   bus tasks wait on handshakes under a bounded count
`timescale 1ns/1ps
`default_nettype none
module ldcfg_bank_test;
	import ldcfg_pkg::*;
	logic        clk_sys = 0, sys_rst = 1;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, io_read, iov, v;
	logic        act;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] io_addr;
	logic [7:0]  io_rdata, d8;
	logic [3:0]  irq0, irq1;
	logic [2:0]  dma;
	int          fail_count = 0, cmp_count = 0;
	logic [7:0]  ix [9] = '{IDX_IO_BASE1_HIGH, IDX_IO_BASE1_LOW,
		IDX_IO_BASE2_HIGH, IDX_IO_BASE2_LOW, IDX_IRQ_LEVEL_SEL0,
		IDX_IRQ_TYPE_SEL0, IDX_IRQ_LEVEL_SEL1, IDX_IRQ_TYPE_SEL1,
		IDX_DMA_CHANNEL_SEL0};
	logic [7:0]  vl [9] = '{8'hA1, 8'h5E, 8'h03, 8'hF8, 8'h0F, 8'h01,
		8'h0A, 8'h01, 8'h07};
	// device and far side
	ldcfg_bank ldcfg_bank_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_addr(io_addr),
		.io_read(io_read), .io_rdata(io_rdata), .io_rdata_valid(iov),
		.device_active(act), .interrupt_line_number0(irq0),
		.interrupt_line_number1(irq1), .dma_channel(dma));
	isa_host_probe isa_host_probe_inst (.clk_sys(clk_sys),
		.io_addr(io_addr), .io_read(io_read), .io_rdata(io_rdata),
		.io_rdata_valid(iov));
	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;
	task automatic results;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] i, input logic [7:0] x,
		output logic [1:0] rs);
		bit b = 0;
		@(posedge clk_sys);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h00_0000, x};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 1000 && !b; k++) begin
			@(posedge clk_sys);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				b = 1;
				rs = bresp;
				bready <= 1'b0;
			end
		end
		if (!b) begin
			fail_count++;
			results();
		end
	endtask
	// one read: address held until taken, rready held until data seen
	task automatic rd(input logic [7:0] i, output logic [31:0] x,
		output logic [1:0] rs);
		bit b = 0;
		@(posedge clk_sys);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 1000 && !b; k++) begin
			@(posedge clk_sys);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				b = 1;
				x = rdata;
				rs = rresp;
				rready <= 1'b0;
			end
		end
		if (!b) begin
			fail_count++;
			results();
		end
	endtask
	task automatic wrc(input logic [7:0] i, input logic [7:0] x);
		wr(i, x, r);
		chk("bresp", r, RESP_OKAY);
	endtask
	task automatic rdc(string n, input logic [7:0] i, input logic [7:0] e);
		rd(i, d, r);
		chk(n, d, e);
		chk("rresp", r, RESP_OKAY);
	endtask
	// start one memory operation and poll the status until done
	task automatic run(input logic [1:0] op);
		wrc(IDX_PROGRAM_COMMAND, {5'h00, 1'b1, op});
		rdc("busy", IDX_PROGRAM_STATUS, 8'h00);
		d = 0;
		for (int k = 0; k < 400 && d[0] !== 1'b1; k++)
			rd(IDX_PROGRAM_STATUS, d, r);
		chk("done", d, 8'h01);
		if (d[0] !== 1'b1)
			results();
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdc("act", IDX_DEVICE_ACTIVATION, 8'h00);
		rdc("dma", IDX_DMA_CHANNEL_SEL0, 8'h04);
		rdc("stat", IDX_PROGRAM_STATUS, 8'h01);
		wrc(IDX_DEVICE_ACTIVATION, 8'hFF);
		rdc("act", IDX_DEVICE_ACTIVATION, 8'h01);
		chk("active", act, 1'b1);
		wrc(IDX_DEVICE_ACTIVATION, 8'h00);
		wrc(IDX_IO_BASE0_HIGH, 8'h12);
		wrc(IDX_IO_BASE0_LOW, 8'h34);
		rdc("b0h", IDX_IO_BASE0_HIGH, 8'h12);
		rdc("b0l", IDX_IO_BASE0_LOW, 8'h34);
		wrc(IDX_RANGE_CHECK, 8'hFF);
		rdc("rc", IDX_RANGE_CHECK, 8'h03);
		isa_host_probe_inst.probe(16'h1234, d8, v);
		chk("io set", {v, d8}, 9'h155);
		wrc(IDX_RANGE_CHECK, 8'h02);
		isa_host_probe_inst.probe(16'h1234, d8, v);
		chk("io clr", {v, d8}, 9'h1AA);
		// range check cleared before activation, then enabled while active
		wrc(IDX_RANGE_CHECK, 8'h00);
		wrc(IDX_DEVICE_ACTIVATION, 8'h01);
		wrc(IDX_RANGE_CHECK, 8'h02);
		isa_host_probe_inst.probe(16'h1234, d8, v);
		chk("io act", v, 1'b0);
		wrc(IDX_RANGE_CHECK, 8'h00);
		wrc(IDX_DEVICE_ACTIVATION, 8'h00);
		foreach (ix[k])
			wrc(ix[k], vl[k]);
		foreach (ix[k])
			rdc("cfg", ix[k], vl[k]);
		chk("irq0", irq0, 4'hF);
		chk("irq1", irq1, 4'hA);
		chk("dmach", dma, 3'h7);
		wrc(IDX_DEVICE_SELECT, 8'h01);
		rdc("dev1", IDX_IRQ_LEVEL_SEL0, 8'h00);
		chk("dev1 dma", dma, 3'h4);
		wrc(IDX_DEVICE_SELECT, 8'h00);
		rdc("dev0", IDX_IRQ_LEVEL_SEL0, 8'h0F);
		wr(8'hFF, 8'h01, r);
		chk("unmapped w", r, RESP_SLVERR);
		rd(8'hFF, d, r);
		chk("unmapped r", d, 32'h0000_0000);
		chk("unmapped rresp", r, RESP_SLVERR);
		wr(IDX_PROGRAM_STATUS, 8'h00, r);
		chk("stat w", r, RESP_SLVERR);
		wrc(IDX_PROGRAM_ADDRESS, 8'h10);
		wrc(IDX_PROGRAM_DATA_HIGH, 8'hA5);
		wrc(IDX_PROGRAM_DATA_LOW, 8'hC3);
		run(OP_WRITE);
		wrc(IDX_PROGRAM_DATA_HIGH, 8'h00);
		wrc(IDX_PROGRAM_DATA_LOW, 8'h00);
		run(OP_READ);
		rdc("mem hi", IDX_PROGRAM_DATA_HIGH, 8'hA5);
		rdc("mem lo", IDX_PROGRAM_DATA_LOW, 8'hC3);
		run(OP_ERASE);
		run(OP_READ);
		rdc("erased", IDX_PROGRAM_DATA_LOW, 8'hFF);
		// command without the proceed flag must not start anything
		wrc(IDX_PROGRAM_DATA_LOW, 8'h00);
		wrc(IDX_PROGRAM_COMMAND, {6'h00, OP_READ});
		rdc("idle", IDX_PROGRAM_STATUS, 8'h01);
		repeat (PROG_CYCLES + 8) @(posedge clk_sys);
		rdc("no load", IDX_PROGRAM_DATA_LOW, 8'h00);
		results();
	end
endmodule // ldcfg_bank_test
`default_nettype wire

// file: ldcfg_pkg.sv
// Purpose: constants shared by the logical device configuration bank
// Assumes: AXI4-Lite register access, byte address = 4 * register index
// Notes:   offsets are register indices; byte addresses derive from them
package ldcfg_pkg;
	// register indices
	localparam logic [7:0] IDX_PROGRAM_STATUS    = 8'h05;
	localparam logic [7:0] IDX_DEVICE_SELECT     = 8'h07;
	localparam logic [7:0] IDX_DEVICE_ACTIVATION = 8'h30;
	localparam logic [7:0] IDX_RANGE_CHECK       = 8'h31;
	localparam logic [7:0] IDX_IO_BASE0_HIGH     = 8'h60;
	localparam logic [7:0] IDX_IO_BASE0_LOW      = 8'h61;
	localparam logic [7:0] IDX_IO_BASE1_HIGH     = 8'h62;
	localparam logic [7:0] IDX_IO_BASE1_LOW      = 8'h63;
	localparam logic [7:0] IDX_IO_BASE2_HIGH     = 8'h64;
	localparam logic [7:0] IDX_IO_BASE2_LOW      = 8'h65;
	localparam logic [7:0] IDX_IRQ_LEVEL_SEL0    = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE_SEL0     = 8'h71;
	localparam logic [7:0] IDX_IRQ_LEVEL_SEL1    = 8'h72;
	localparam logic [7:0] IDX_IRQ_TYPE_SEL1     = 8'h73;
	localparam logic [7:0] IDX_DMA_CHANNEL_SEL0  = 8'h74;
	localparam logic [7:0] IDX_PROGRAM_COMMAND   = 8'hF0;
	localparam logic [7:0] IDX_PROGRAM_ADDRESS   = 8'hF1;
	localparam logic [7:0] IDX_PROGRAM_DATA_HIGH = 8'hF2;
	localparam logic [7:0] IDX_PROGRAM_DATA_LOW  = 8'hF3;
	// field positions and values
	localparam int ACT_BIT         = 0;
	localparam int RC_PATTERN_BIT  = 0;
	localparam int RC_ENABLE_BIT   = 1;
	localparam int CMD_PROCEED_BIT = 2;
	localparam logic [1:0] OP_READ  = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;
	localparam logic [1:0] OP_ERASE = 2'b11;
	localparam logic [7:0] RC_PATTERN_SET   = 8'h55;
	localparam logic [7:0] RC_PATTERN_CLEAR = 8'hAA;
	// reset and erase values
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [7:0] RESET_DMA_NONE  = 8'h04;
	localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
	// memory and device geometry
	localparam int NUM_DEVICES  = 4;
	localparam int MEM_WORDS    = 256;
	// programming cycle time
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int PROG_TIME_NS   = 1000;
	localparam int PROG_CYCLES    = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
